// *** rtl/sks_top.sv ***
// Operation
// - Slider starts at first drive line, receive line one
// - Host sets slider length; other keys stay independent
// - Position resolution programmable from 2 to 8 bits
// - Slider acts as one object in grouping
// - Three groups, one reported object each
// - Dominant touched member holds group until released
// - Group 1 to 3 joins; 0 exempts key
// - No suppression among slider keys
// - First touched of slider or keys wins
// - Per-key integrator counts to limit, miss clears
// - Change output low when key status changes
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module sks_top
(
  input wire logic clock,
  input wire logic rst,
  input wire logic acq_valid,
  input wire logic [sks_pkg::NUM_KEYS-1:0] acq_above,
  input wire logic awvalid,
  output logic awready,
  input wire logic [sks_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [sks_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic [sks_pkg::NUM_KEYS-1:0] key_report,
  output logic slider_active,
  output logic [7:0] slider_pos,
  output logic chg_n,
  output logic irq
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] slider_mask(input logic [3:0] len);
    logic [15:0] m;
    m = 16'h0000;
    if (len >= sks_pkg::SLEN_MIN && len <= sks_pkg::SLEN_MAX)
    begin
      for (int i = 0; i < sks_pkg::LINE_KEYS; i++)
      begin
        m[i] = (4'(i) < len);
      end
    end
    return m;
  endfunction

  function automatic logic [1:0] key_grp(input logic [31:0] grps, input logic [3:0] k);
    return grps[{k, 1'b0} +: 2];
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (s[b])
      begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  logic [31:0] ctrl_r;
  logic [31:0] groups_r;
  logic [sks_pkg::EV_W-1:0] ien_r;
  logic [sks_pkg::EV_W-1:0] istat_r;
  logic [sks_pkg::EV_W-1:0] istat_nxt;
  logic [15:0] det;
  logic eval_r;
  logic [4:0] owner_r [sks_pkg::NUM_GROUPS];
  logic [4:0] owner_nxt [sks_pkg::NUM_GROUPS];
  logic [2:0] owner_v_r;
  logic [2:0] owner_v_nxt;
  logic [15:0] rep_r;
  logic [15:0] rep_nxt;
  logic sl_act_r;
  logic [7:0] pos_r;
  logic [7:0] pos_nxt;
  logic [15:0] smask;
  logic [15:0] det_ns;
  logic sl_any;
  logic [1:0] sl_grp;
  logic [1:0] gid;
  logic own_ok;
  logic [3:0] slen;
  logic [3:0] res;
  logic [3:0] lo;
  logic [3:0] hi;
  logic [11:0] prod;
  logic [11:0] full;
  logic [4:0] den;
  logic ev_key;
  logic ev_pos;

  assign slen = ctrl_r[sks_pkg::SLEN_LSB +: 4];
  assign smask = slider_mask(slen);

  // ****************************************************************
  // Per-key detection integrators
  // ****************************************************************
  for (genvar k = 0; k < sks_pkg::NUM_KEYS; k++)
  begin : g_int
    sks_integrator u_int
    (
      .clock(clock),
      .rst(rst),
      .acq_valid(acq_valid),
      .above(acq_above[k]),
      .limit(ctrl_r[sks_pkg::LIMIT_LSB +: sks_pkg::CNT_W]),
      .detect(det[k])
    );
  end

  // ****************************************************************
  // Group arbitration and reporting
  // ****************************************************************
  // Decisions are taken one cycle after each acquisition, once the
  // integrators have settled on their new counts.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      eval_r <= 1'b0;
    end
    else
    begin
      eval_r <= acq_valid;
    end
  end

  always_comb
  begin
    det_ns = det & ~smask;
    sl_any = |(det & smask);
    sl_grp = key_grp(groups_r, 4'h0);
    gid = 2'h0;
    own_ok = 1'b0;
    for (int g = 0; g < sks_pkg::NUM_GROUPS; g++)
    begin
      gid = 2'(g + 1);
      own_ok = 1'b0;
      if (owner_v_r[g])
      begin
        if (owner_r[g] == sks_pkg::SLIDER_OBJ)
        begin
          own_ok = sl_any && (sl_grp == gid);
        end
        else
        begin
          own_ok = det_ns[owner_r[g][3:0]] && (key_grp(groups_r, owner_r[g][3:0]) == gid);
        end
      end
      owner_v_nxt[g] = own_ok;
      owner_nxt[g] = owner_r[g];
      // A newcomer only wins a group that nobody holds, so the first touch rules.
      if (!own_ok)
      begin
        if (sl_any && (sl_grp == gid))
        begin
          owner_v_nxt[g] = 1'b1;
          owner_nxt[g] = sks_pkg::SLIDER_OBJ;
        end
        else
        begin
          for (int k = sks_pkg::NUM_KEYS - 1; k >= 0; k--)
          begin
            if (det_ns[k] && (key_grp(groups_r, 4'(k)) == gid))
            begin
              owner_v_nxt[g] = 1'b1;
              owner_nxt[g] = 5'(k);
            end
          end
        end
      end
    end
    for (int k = 0; k < sks_pkg::NUM_KEYS; k++)
    begin
      if (smask[k])
      begin
        rep_nxt[k] = det[k] && ((sl_grp == 2'h0) ||
                     (owner_v_nxt[sl_grp - 2'h1] &&
                      owner_nxt[sl_grp - 2'h1] == sks_pkg::SLIDER_OBJ));
      end
      else if (key_grp(groups_r, 4'(k)) == 2'h0)
      begin
        rep_nxt[k] = det[k];
      end
      else
      begin
        rep_nxt[k] = det[k] && owner_v_nxt[key_grp(groups_r, 4'(k)) - 2'h1] &&
                     (owner_nxt[key_grp(groups_r, 4'(k)) - 2'h1] == 5'(k));
      end
    end
  end

  // ****************************************************************
  // Slider position
  // ****************************************************************
  // The position is the centre of the touched span of slider keys, scaled
  // to the full range and then cut to the programmed resolution.
  always_comb
  begin
    lo = 4'h0;
    hi = 4'h0;
    for (int k = sks_pkg::LINE_KEYS - 1; k >= 0; k--)
    begin
      if (det[k] && smask[k])
      begin
        lo = 4'(k);
      end
    end
    for (int k = 0; k < sks_pkg::LINE_KEYS; k++)
    begin
      if (det[k] && smask[k])
      begin
        hi = 4'(k);
      end
    end
    res = ctrl_r[sks_pkg::RES_LSB +: 4];
    if (res < sks_pkg::RES_MIN)
    begin
      res = sks_pkg::RES_MIN;
    end
    else if (res > sks_pkg::RES_MAX)
    begin
      res = sks_pkg::RES_MAX;
    end
    prod = 12'(lo + hi) * sks_pkg::POS_FULL;
    den = (slen < sks_pkg::SLEN_MIN) ? 5'h02 : {slen - 4'h1, 1'b0};
    full = prod / 12'(den);
    pos_nxt = 8'(full >> (sks_pkg::RES_MAX - res));
  end

  assign ev_key = eval_r && (rep_nxt != rep_r);
  assign ev_pos = eval_r && sl_any && (pos_nxt != pos_r);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      owner_v_r <= 3'h0;
      for (int g = 0; g < sks_pkg::NUM_GROUPS; g++)
      begin
        owner_r[g] <= 5'h00;
      end
      rep_r <= 16'h0000;
      sl_act_r <= 1'b0;
      pos_r <= 8'h00;
    end
    else if (eval_r)
    begin
      owner_v_r <= owner_v_nxt;
      for (int g = 0; g < sks_pkg::NUM_GROUPS; g++)
      begin
        owner_r[g] <= owner_nxt[g];
      end
      rep_r <= rep_nxt;
      sl_act_r <= |(rep_nxt & smask);
      if (sl_any)
      begin
        pos_r <= pos_nxt;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic aw_have_r;
  logic w_have_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic do_write;
  logic aw_have_nxt;
  logic w_have_nxt;
  logic bvalid_nxt;
  logic rvalid_nxt;
  logic ar_fire;
  logic wr_ok;
  logic [31:0] rd_val;
  logic rd_ok;

  assign do_write = aw_have_r && w_have_r && !bvalid;
  assign aw_have_nxt = do_write ? 1'b0 : (aw_have_r || (awvalid && awready));
  assign w_have_nxt = do_write ? 1'b0 : (w_have_r || (wvalid && wready));
  assign bvalid_nxt = do_write || (bvalid && !bready);
  assign ar_fire = arvalid && arready;
  assign rvalid_nxt = ar_fire || (rvalid && !rready);
  assign wr_ok = (aw_addr_r == sks_pkg::CTRL_ADDR) || (aw_addr_r == sks_pkg::GROUP_ADDR) ||
                 (aw_addr_r == sks_pkg::IEN_ADDR) || (aw_addr_r == sks_pkg::ICLR_ADDR);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= sks_pkg::RESP_OKAY;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end
    else
    begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      awready <= !aw_have_nxt && !bvalid_nxt;
      wready <= !w_have_nxt && !bvalid_nxt;
      bvalid <= bvalid_nxt;
      if (awvalid && awready)
      begin
        aw_addr_r <= {awaddr[7:2], 2'h0};
      end
      if (wvalid && wready)
      begin
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (do_write)
      begin
        bresp <= wr_ok ? sks_pkg::RESP_OKAY : sks_pkg::RESP_SLVERR;
      end
    end
  end

  always_comb
  begin
    rd_ok = 1'b1;
    rd_val = 32'h0000_0000;
    unique case ({araddr[7:2], 2'h0})
      sks_pkg::CTRL_ADDR: rd_val = ctrl_r;
      sks_pkg::GROUP_ADDR: rd_val = groups_r;
      sks_pkg::KEYSTAT_ADDR: rd_val = {15'h0000, sl_act_r, rep_r};
      sks_pkg::SLPOS_ADDR: rd_val = {24'h000000, pos_r};
      sks_pkg::ISTAT_ADDR: rd_val = {30'h00000000, istat_r};
      sks_pkg::IEN_ADDR: rd_val = {30'h00000000, ien_r};
      sks_pkg::ICLR_ADDR: rd_val = 32'h0000_0000;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= sks_pkg::RESP_OKAY;
    end
    else
    begin
      arready <= !rvalid_nxt;
      rvalid <= rvalid_nxt;
      if (ar_fire)
      begin
        rdata <= rd_val;
        rresp <= rd_ok ? sks_pkg::RESP_OKAY : sks_pkg::RESP_SLVERR;
      end
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r <= {8'h00, sks_pkg::LIMIT_RST, 4'h0, sks_pkg::RES_RST, 4'h0, sks_pkg::SLEN_RST};
      groups_r <= sks_pkg::GROUP_RST;
      ien_r <= 2'h0;
    end
    else if (do_write)
    begin
      if (aw_addr_r == sks_pkg::CTRL_ADDR)
      begin
        ctrl_r <= apply_strb(ctrl_r, w_data_r, w_strb_r) & 32'h00FF_0F0F;
      end
      if (aw_addr_r == sks_pkg::GROUP_ADDR)
      begin
        groups_r <= apply_strb(groups_r, w_data_r, w_strb_r);
      end
      if (aw_addr_r == sks_pkg::IEN_ADDR && w_strb_r[0])
      begin
        ien_r <= w_data_r[sks_pkg::EV_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Interrupt and change line
  // ****************************************************************
  // New events win over a clear in the same cycle, so none is lost. Reading
  // the key status also acknowledges the key event, as a host polling on the
  // change line would expect.
  always_comb
  begin
    istat_nxt = istat_r;
    if (do_write && aw_addr_r == sks_pkg::ICLR_ADDR && w_strb_r[0])
    begin
      istat_nxt = istat_nxt & ~w_data_r[sks_pkg::EV_W-1:0];
    end
    if (ar_fire && {araddr[7:2], 2'h0} == sks_pkg::KEYSTAT_ADDR)
    begin
      istat_nxt[sks_pkg::EV_KEY] = 1'b0;
    end
    istat_nxt[sks_pkg::EV_KEY] = istat_nxt[sks_pkg::EV_KEY] | ev_key;
    istat_nxt[sks_pkg::EV_POS] = istat_nxt[sks_pkg::EV_POS] | ev_pos;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      istat_r <= 2'h0;
      irq <= 1'b0;
      chg_n <= 1'b1;
    end
    else
    begin
      istat_r <= istat_nxt;
      irq <= |(istat_nxt & ien_r);
      chg_n <= !istat_nxt[sks_pkg::EV_KEY];
    end
  end

  assign key_report = rep_r;
  assign slider_active = sl_act_r;
  assign slider_pos = pos_r;

endmodule

`default_nettype wire

// *** rtl/sks_pkg.sv ***
package sks_pkg;

  // ****************************************************************
  // Geometry of the key matrix
  // ****************************************************************
  localparam int NUM_KEYS = 16;
  localparam int LINE_KEYS = 8;
  localparam int NUM_GROUPS = 3;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 8;
  localparam logic [4:0] SLIDER_OBJ = 5'h10;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] GROUP_ADDR = 8'h04;
  localparam logic [7:0] KEYSTAT_ADDR = 8'h08;
  localparam logic [7:0] SLPOS_ADDR = 8'h0C;
  localparam logic [7:0] ISTAT_ADDR = 8'h10;
  localparam logic [7:0] IEN_ADDR = 8'h14;
  localparam logic [7:0] ICLR_ADDR = 8'h18;

  // ****************************************************************
  // Field positions of the control register
  // ****************************************************************
  localparam int SLEN_LSB = 0;
  localparam int RES_LSB = 8;
  localparam int LIMIT_LSB = 16;

  // ****************************************************************
  // Values after reset and limits
  // ****************************************************************
  localparam logic [3:0] SLEN_RST = 4'h0;
  localparam logic [3:0] RES_RST = 4'h8;
  localparam logic [7:0] LIMIT_RST = 8'h0A;
  localparam logic [31:0] GROUP_RST = 32'h0000_0000;
  localparam logic [3:0] SLEN_MIN = 4'h2;
  localparam logic [3:0] SLEN_MAX = 4'h8;
  localparam logic [3:0] RES_MIN = 4'h2;
  localparam logic [3:0] RES_MAX = 4'h8;
  localparam logic [11:0] POS_FULL = 12'h0FF;

  // ****************************************************************
  // Event bits of the interrupt registers
  // ****************************************************************
  localparam int EV_KEY = 0;
  localparam int EV_POS = 1;
  localparam int EV_W = 2;

  // ****************************************************************
  // Bus responses
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** rtl/sks_integrator.sv ***
`timescale 1ns/1ps
`default_nettype none

// Debounce of one key: a run of above-threshold acquisitions must reach the
// limit before the key counts as detected; a single miss starts over.
module sks_integrator
(
  input wire logic clock,
  input wire logic rst,
  input wire logic acq_valid,
  input wire logic above,
  input wire logic [sks_pkg::CNT_W-1:0] limit,
  output logic detect
);

  logic [sks_pkg::CNT_W-1:0] cnt_r;
  logic [sks_pkg::CNT_W-1:0] eff_limit;

  // A limit of zero would declare touch without any evidence, so it acts as one.
  assign eff_limit = (limit == 8'h00) ? 8'h01 : limit;
  assign detect = (cnt_r >= eff_limit);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 8'h00;
    end
    else if (acq_valid)
    begin
      if (!above)
      begin
        cnt_r <= 8'h00;
      end
      else if (cnt_r < eff_limit)
      begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end

endmodule

`default_nettype wire

// *** dv/sks_top_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none

module sks_top_asserts
(
  input wire logic clock,
  input wire logic rst,
  input wire logic acq_valid,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [sks_pkg::NUM_KEYS-1:0] key_report,
  input wire logic slider_active,
  input wire logic [7:0] slider_pos,
  input wire logic chg_n
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // ********************
  // Named steps
  // ********************
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_taken;
    arvalid && arready;
  endsequence
  sequence key_moved;
    $changed(key_report);
  endsequence

  // Reported status only moves on the evaluation that follows an acquisition.
  a_key_stand: assert property (key_moved |-> $past(acq_valid, 2))
    else $error("key report moved without an acquisition");
  a_pos_stand: assert property ($changed(slider_pos) |-> $past(acq_valid, 2))
    else $error("slider position moved without an acquisition");
  a_slider_obj: assert property (slider_active |-> (|key_report[7:0]))
    else $error("slider flagged with no first line key reported");
  a_chg_follow: assert property (key_moved |=> !chg_n)
    else $error("change line not low after key status change");
  a_wr_answer: assert property (wr_taken |-> ##2 bvalid)
    else $error("write response not two cycles after handshake");
  a_b_stand: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rd_answer: assert property (rd_taken |=> rvalid && !arready)
    else $error("read data not one cycle after handshake");
  a_r_stand: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_aw_refused: assert property (bvalid |-> !awready && !wready)
    else $error("new write accepted while response pending");
endmodule

bind sks_top sks_top_asserts u_chk
(
  .clock(clock), .rst(rst), .acq_valid(acq_valid), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .key_report(key_report), .slider_active(slider_active), .slider_pos(slider_pos),
  .chg_n(chg_n)
);

`default_nettype wire

// *** dv/sks_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Host side of the register bus. Released payloads are inverted so a stale value never
// looks like a valid one.
module sks_host_model
(
  input wire logic clock,
  output logic awvalid,
  input wire logic awready,
  output logic [7:0] awaddr,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  output logic arvalid,
  input wire logic arready,
  output logic [7:0] araddr,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
    output bit to);
    to = 1'b1;
    r = 2'h3;
    @(posedge clock);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    for (int n = 0; n < 100 && to; n++)
    begin
      @(posedge clock);
      if (awvalid && awready)
      begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready)
      begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid && !bready)
        bready <= 1'b1;
      if (bvalid && bready)
      begin
        bready <= 1'b0;
        r = bresp;
        to = 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
    output bit to);
    to = 1'b1;
    d = 32'h0;
    r = 2'h3;
    @(posedge clock);
    arvalid <= 1'b1;
    araddr <= a;
    for (int n = 0; n < 100 && to; n++)
    begin
      @(posedge clock);
      if (arvalid && arready)
      begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid && !rready)
        rready <= 1'b1;
      if (rvalid && rready)
      begin
        rready <= 1'b0;
        d = rdata;
        r = rresp;
        to = 1'b0;
      end
    end
  endtask
endmodule

`default_nettype wire

// *** dv/sks_top_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module sks_top_tb_top;
  typedef struct packed
  {
    logic [15:0] key;
    logic [7:0] pos;
    logic pchk;
    logic act;
  } sks_note_t;

  logic clock, rst, acq_valid, d1, d2, pos_unk, slider_active, chg_n, irq;
  logic [15:0] acq_above, key_report, rep_e, lf;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, slider_pos, pos_e;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int err_total, checked, sl, res, lim;
  int cnt[16], g[16], own[4];
  sks_note_t q[$];
  sks_note_t mn;
  logic [15:0] pat[10] = '{16'h0003, 16'h0013, 16'h0010, 16'h0011, 16'h0060, 16'h0040,
    16'h0060, 16'h0080, 16'h0108, 16'h0100};

  sks_top dut
  (
    .clock(clock), .rst(rst), .acq_valid(acq_valid), .acq_above(acq_above),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .key_report(key_report), .slider_active(slider_active),
    .slider_pos(slider_pos), .chg_n(chg_n), .irq(irq)
  );

  sks_host_model u_host
  (
    .clock(clock), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp)
  );

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic close_out();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    bit to;
    u_host.wr(a, d, r, to);
    if (to)
    begin
      err_total++;
      close_out();
    end
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    bit to;
    u_host.rd(a, d, r, to);
    if (to)
    begin
      err_total++;
      close_out();
    end
    chk("rdata", e, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic cfg(input int l, input int r, input int m);
    wreg(sks_pkg::CTRL_ADDR, 32'(l) | (32'(r) << sks_pkg::RES_LSB) |
      (32'(m) << sks_pkg::LIMIT_LSB), sks_pkg::RESP_OKAY);
    sl = (l >= 2 && l <= 8) ? l : 0;
    res = r;
    lim = m;
  endtask

  task automatic grp(input logic [31:0] v);
    wreg(sks_pkg::GROUP_ADDR, v, sks_pkg::RESP_OKAY);
    for (int k = 0; k < 16; k++)
      g[k] = v[2*k +: 2];
  endtask

  // ********************
  // Expected report: debounce, then one owner per group with the slider as one object.
  // ********************
  task automatic model(input logic [15:0] ab);
    logic [15:0] raw;
    logic [15:0] sm;
    sks_note_t n;
    int o;
    int lo;
    int hi;
    sm = 16'h0;
    for (int k = 0; k < sl; k++)
      sm[k] = 1'b1;
    for (int k = 0; k < 16; k++)
    begin
      cnt[k] = ab[k] ? cnt[k] + 1 : 0;
      raw[k] = cnt[k] >= lim;
    end
    rep_e = raw;
    for (int gg = 1; gg < 4; gg++)
    begin
      o = own[gg];
      if (!(o == 16 ? ((|(raw & sm)) && g[0] == gg) :
        (o >= sl && o >= 0 && raw[o] && g[o] == gg)))
      begin
        o = -1;
        for (int k = 15; k >= sl; k--)
          if (raw[k] && g[k] == gg)
            o = k;
        if ((|(raw & sm)) && g[0] == gg)
          o = 16;
      end
      own[gg] = o;
      for (int k = 0; k < 16; k++)
        if ((k < sl ? g[0] : g[k]) == gg && !(k < sl ? o == 16 : o == k))
          rep_e[k] = 1'b0;
    end
    if (|(rep_e & sm))
    begin
      lo = 15;
      hi = 0;
      for (int k = 0; k < 16; k++)
        if (rep_e[k] && sm[k])
        begin
          lo = (k < lo) ? k : lo;
          hi = k;
        end
      pos_e = 8'((((lo + hi) * 255) / (2 * (sl - 1))) >> (8 - res));
      pos_unk = 1'b0;
    end
    else if (|(raw & sm))
      pos_unk = 1'b1;
    n.key = rep_e;
    n.pos = pos_e;
    n.pchk = !pos_unk;
    n.act = |(rep_e & sm);
    q.push_back(n);
  endtask

  task automatic acq(input logic [15:0] v);
    @(posedge clock);
    acq_valid <= 1'b1;
    acq_above <= v;
    model(v);
    @(posedge clock);
    acq_valid <= 1'b0;
    acq_above <= ~v;
  endtask

  task automatic settle();
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask

  always @(posedge clock)
  begin
    d1 <= acq_valid;
    d2 <= d1;
  end

  always @(negedge clock)
    if (d2 && !rst)
    begin
      if (q.size() == 0)
        chk("note queue", 32'h1, 32'h0);
      else
      begin
        mn = q.pop_front();
        chk("key_report", {16'h0, mn.key}, {16'h0, key_report});
        if (mn.pchk)
          chk("slider_pos", {24'h0, mn.pos}, {24'h0, slider_pos});
        chk("slider_active", {31'h0, mn.act}, {31'h0, slider_active});
      end
    end

  initial
  begin
    #900000;
    chk("run time", 32'h0, 32'h1);
    close_out();
  end

  initial
  begin
    {rst, acq_valid, d1, d2, pos_unk} = 5'h10;
    {acq_above, pos_e, err_total, checked, sl, res, lim} = {24'h0, 32'h0, 32'h0, 32'h0, 32'h8, 32'hA};
    lf = 16'h0E3C;
    foreach (cnt[k])
      {cnt[k], g[k]} = 64'h0;
    foreach (own[k])
      own[k] = -1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rreg(sks_pkg::CTRL_ADDR, 32'h000A_0800, sks_pkg::RESP_OKAY);
    rreg(sks_pkg::GROUP_ADDR, 32'h0, sks_pkg::RESP_OKAY);
    rreg(sks_pkg::IEN_ADDR, 32'h0, sks_pkg::RESP_OKAY);
    rreg(sks_pkg::ICLR_ADDR, 32'h0, sks_pkg::RESP_OKAY);
    rreg(8'h1C, 32'h0, sks_pkg::RESP_SLVERR);
    wreg(8'h1C, 32'hFFFF_FFFF, sks_pkg::RESP_SLVERR);
    $display("test registers done");
    repeat (9) acq(16'h0200);
    acq(16'h0000);
    repeat (10) acq(16'h0200);
    $display("test integrator done");
    cfg(0, 8, 1);
    repeat (20)
    begin
      lf = lfsr(lf);
      acq(lf);
    end
    $display("test random exempt keys done");
    cfg(4, 8, 1);
    grp(32'h0000_E955);
    foreach (pat[i])
      acq(pat[i]);
    settle();
    rreg(sks_pkg::KEYSTAT_ADDR, {15'h0, |rep_e[3:0], rep_e}, sks_pkg::RESP_OKAY);
    rreg(sks_pkg::SLPOS_ADDR, {24'h0, pos_e}, sks_pkg::RESP_OKAY);
    for (int r = 2; r <= 8; r++)
    begin
      cfg(4, r, 1);
      acq(16'h0006);
    end
    $display("test slider and groups done");
    wreg(sks_pkg::ICLR_ADDR, 32'h3, sks_pkg::RESP_OKAY);
    acq(16'h0008);
    settle();
    rreg(sks_pkg::ISTAT_ADDR, 32'h3, sks_pkg::RESP_OKAY);
    wreg(sks_pkg::IEN_ADDR, 32'h1, sks_pkg::RESP_OKAY);
    settle();
    chk("chg_n", 32'h0, {31'h0, chg_n});
    chk("irq", 32'h1, {31'h0, irq});
    wreg(sks_pkg::IEN_ADDR, 32'h0, sks_pkg::RESP_OKAY);
    settle();
    chk("irq", 32'h0, {31'h0, irq});
    wreg(sks_pkg::ICLR_ADDR, 32'h1, sks_pkg::RESP_OKAY);
    settle();
    chk("chg_n", 32'h1, {31'h0, chg_n});
    rreg(sks_pkg::ISTAT_ADDR, 32'h2, sks_pkg::RESP_OKAY);
    $display("test interrupt done");
    close_out();
  end
endmodule

`default_nettype wire
